// >>> tb/ehd_properties.sv
// port-level properties of the extend and hint decode unit
// assumes a bind onto the top module; sees its ports only
`timescale 1ns/10ps
module ehd_properties
    import ext_hint_pkg::*;
(
    input wire logic clk_i,
    input wire logic rst_i,
    input wire issue_t issue_i,
    input wire logic event_set_i,
    input wire logic send_event_i,
    input wire logic wake_event_i,
    input wire wake_req_t exc_i,
    input wire logic [PRIO_W-1:0] exec_prio_i,
    input wire reg_wr_t reg_wr_o,
    input wire logic stall_o,
    input wire logic low_power_o,
    input wire logic pc_advance_o,
    input wire logic event_clear_o,
    input wire logic flags_write_o,
    input wire logic exception_o
);
    default clocking cb @(posedge clk_i);
    endclocking
    default disable iff (rst_i);
    logic take, woken;
    logic [15:0] op;
    assign op = issue_i.opcode;
    assign take = issue_i.valid && issue_i.cond_pass && !stall_o;
    assign woken = wake_event_i ||
        (exc_i.pending && exc_i.group_prio < exec_prio_i);
    a_cond_fail_idle: assert property (
        issue_i.valid && !issue_i.cond_pass && !stall_o
        |=> !pc_advance_o && !stall_o) else $error("failed condition acted");
    a_take_advance: assert property (
        take |=> pc_advance_o) else $error("no advance after issue");
    a_wait_enter: assert property (
        take && (op == WAIT_INTR_OP || op == WAIT_EVENT_OP && !event_set_i)
        |=> stall_o && low_power_o) else $error("wait not entered");
    a_event_consume: assert property (
        take && op == WAIT_EVENT_OP && event_set_i
        |=> event_clear_o && !stall_o) else $error("event not consumed");
    a_zext_write: assert property (
        take && (op[15:6] == BYTE_ZEXT_OP || op[15:6] == HALF_ZEXT_OP)
        |=> ##1 reg_wr_o.en && reg_wr_o.idx == $past(op[2:0], 2)
        && reg_wr_o.data[31:16] == 16'h0
        && (reg_wr_o.data[15:8] & {8{$past(op[6], 2)}}) == 8'h0)
        else $error("bad extend write");
    a_yield_quiet: assert property (
        take && op == YIELD_OP && !pc_advance_o
        |=> !stall_o ##1 !reg_wr_o.en) else $error("yield acted");
    a_wake_ends: assert property (
        stall_o && woken |=> !stall_o) else $error("wake ignored");
    a_low_prio_holds: assert property (
        stall_o && !woken && !send_event_i
        |=> stall_o) else $error("woke without cause");
    a_no_side_flags: assert property (
        !flags_write_o && !exception_o) else $error("flag or fault raised");
endmodule

bind extend_and_hint_decode ehd_properties u_props (.clk_i, .rst_i,
    .issue_i, .event_set_i, .send_event_i, .wake_event_i, .exc_i,
    .exec_prio_i, .reg_wr_o, .stall_o, .low_power_o, .pc_advance_o,
    .event_clear_o, .flags_write_o, .exception_o);

// >>> tb/exc_source.sv
// exception and wake source model for the decode unit's far side
// assumes one-cycle fire requests from the bench, sampled on rising edges
`timescale 1ns/10ps
module exc_source
    import ext_hint_pkg::*;
(
    input wire logic clk_i,
    input wire logic fire_i,
    input wire logic [1:0] kind_i,
    input wire logic [PRIO_W-1:0] prio_i,
    output wake_req_t exc_o,
    output logic wake_o,
    output logic sev_o
);
    // idle priority is inverted so a stale value never looks meaningful
    always_ff @(posedge clk_i) begin
        exc_o.pending <= fire_i && kind_i == 2'h0;
        exc_o.group_prio <= fire_i ? prio_i : ~prio_i;
        wake_o <= fire_i && kind_i == 2'h1;
        sev_o <= fire_i && kind_i == 2'h2;
    end
endmodule

// >>> tb/extend_and_hint_decode_tb.sv
// self-checking bench for the extend and hint decode unit
// assumes the exception source model drives the wake inputs
`timescale 1ns/10ps
module extend_and_hint_decode_tb
    import ext_hint_pkg::*;
;
    logic clk_i = 1'b0;
    logic rst_i = 1'b1;
    logic event_set_i = 1'b0;
    logic mask_bit = 1'b0;
    logic fire = 1'b0;
    logic [1:0] kind = 2'h0;
    logic [PRIO_W-1:0] prio = 8'h0;
    logic [PRIO_W-1:0] exec_prio = 8'h40;
    issue_t issue_i = '0;
    reg_wr_t ext_wr_i = '0;
    reg_wr_t reg_wr_o;
    wake_req_t exc_i;
    logic send_event_instruction, wake, stall_o, pc_advance_o, ev_clr;
    logic [DATA_W-1:0] result;
    logic [DATA_W-1:0] regs [REG_COUNT];
    logic [31:0] seed = 32'h1a;
    int err_count = 0;
    int checked = 0;
    always #5 clk_i = ~clk_i;
    extend_and_hint_decode u_dut (.clk_i, .rst_i, .issue_i, .event_set_i,
        .send_event_i(send_event_instruction), .wake_event_i(wake), .exc_i,
        .exec_prio_i(exec_prio), .priority_mask_bit_i(mask_bit), .ext_wr_i,
        .reg_wr_o, .stall_o, .low_power_o(), .pc_advance_o,
        .event_clear_o(ev_clr), .flags_write_o(), .exception_o(),
        .result_o(result));
    exc_source u_src (.clk_i, .fire_i(fire), .kind_i(kind), .prio_i(prio),
        .exc_o(exc_i), .wake_o(wake), .sev_o(send_event_instruction));
    function automatic logic [31:0] xs();
        seed ^= seed << 13;
        seed ^= seed >> 17;
        seed ^= seed << 5;
        return seed;
    endfunction
    task automatic chk(input bit ok, input string m);
        checked++;
        if (!ok) begin
            err_count++;
            $display("CHECK FAILED %0t %s", $time, m);
        end
    endtask
    task automatic issue(input logic [15:0] op, input logic cp);
        @(negedge clk_i);
        issue_i <= '{1'b1, cp, op};
        @(negedge clk_i);
        issue_i <= '0;
    endtask
    // waits a bounded span for the wait state to drop
    task automatic pulse(input logic [1:0] k, input logic [PRIO_W-1:0] p);
        @(negedge clk_i);
        fire <= 1'b1;
        kind <= k;
        prio <= p;
        @(negedge clk_i);
        fire <= 1'b0;
        for (int i = 0; i < 4 && stall_o !== 1'b0; i++) @(negedge clk_i);
    endtask
    task automatic conclude();
        $display("mismatches %0d of %0d checks", err_count, checked);
        if (err_count == 0 && checked > 0)
            $display("== PASSED ==");
        else
            $display("== FAILED ==");
        $finish;
    endtask
    initial begin
        logic [31:0] r;
        logic [15:0] op;
        logic [31:0] exp;
        logic cp;
        logic [31:0] last;
        last = '0;
        repeat (2) @(negedge clk_i);
        rst_i <= 1'b0;
        for (int i = 0; i < REG_COUNT; i++) begin
            regs[i] = xs();
            ext_wr_i <= '{1'b1, i[2:0], regs[i]};
            @(negedge clk_i);
        end
        ext_wr_i <= '0;
        for (int n = 0; n < 30; n++) begin
            r = xs();
            cp = r[9:7] != 3'h0;
            op = {r[6] ? BYTE_ZEXT_OP : HALF_ZEXT_OP, r[5:0]};
            exp = r[6] ? {24'h0, regs[r[5:3]][7:0]}
                : {16'h0, regs[r[5:3]][15:0]};
            issue(op, cp);
            chk(pc_advance_o === cp, "advance mismatch");
            @(negedge clk_i);
            chk(reg_wr_o.en === cp, "write enable mismatch");
            chk(result === (cp ? exp : last), "result mismatch");
            if (cp) begin
                chk(reg_wr_o.idx === op[2:0], "zext index");
                chk(reg_wr_o.data === exp, "zext data");
                regs[op[2:0]] = exp;
                last = exp;
            end
        end
        // dependent pair back to back: the second reads the first's target
        exp = {24'h0, regs[1][7:0]};
        @(negedge clk_i);
        issue_i <= '{1'b1, 1'b1, {BYTE_ZEXT_OP, 3'h1, 3'h2}};
        @(negedge clk_i);
        issue_i <= '{1'b1, 1'b1, {HALF_ZEXT_OP, 3'h2, 3'h3}};
        @(negedge clk_i);
        issue_i <= '0;
        chk(reg_wr_o.en === 1'b1 && reg_wr_o.idx === 3'h2, "pair one");
        chk(reg_wr_o.data === exp, "pair one data");
        @(negedge clk_i);
        chk(reg_wr_o.en === 1'b1 && reg_wr_o.idx === 3'h3, "pair two");
        chk(reg_wr_o.data === exp && result === exp, "pair two data");
        regs[2] = exp;
        regs[3] = exp;
        issue(YIELD_OP, 1'b1);
        chk(pc_advance_o === 1'b1 && stall_o === 1'b0, "yield");
        @(negedge clk_i);
        chk(reg_wr_o.en === 1'b0, "yield wrote a register");
        event_set_i = 1'b1;
        issue(WAIT_EVENT_OP, 1'b1);
        chk(ev_clr === 1'b1 && stall_o === 1'b0, "event kept");
        event_set_i = 1'b0;
        issue(WAIT_EVENT_OP, 1'b1);
        chk(stall_o === 1'b1, "event wait not entered");
        pulse(2'h2, 8'h0);
        chk(stall_o === 1'b0, "send event did not wake");
        issue(WAIT_INTR_OP, 1'b0);
        chk(stall_o === 1'b0, "failed wait acted");
        issue(WAIT_INTR_OP, 1'b1);
        issue(YIELD_OP, 1'b1);
        chk(pc_advance_o === 1'b0, "issue taken while waiting");
        pulse(2'h0, exec_prio);
        chk(stall_o === 1'b1, "equal priority woke");
        mask_bit = 1'b1;
        pulse(2'h0, exec_prio - 8'h1);
        chk(stall_o === 1'b0, "higher priority ignored");
        conclude();
    end
    // about fifteen times the expected run length
    initial begin
        #20000;
        err_count++;
        conclude();
    end
endmodule

// >>> verilog/ext_hint_pkg.sv
// shared constants and types for the extend and hint decode unit
// assumes a 16-bit halfword opcode stream and an 8-entry low register set
package ext_hint_pkg;
    localparam int unsigned REG_IDX_W = 3;
    localparam int unsigned DATA_W = 32;
    localparam int unsigned REG_COUNT = 8;
    localparam logic [9:0] BYTE_ZEXT_OP = 10'h2cb;
    localparam logic [9:0] HALF_ZEXT_OP = 10'h2ca;
    localparam logic [15:0] WAIT_EVENT_OP = 16'hbf20;
    localparam logic [15:0] WAIT_INTR_OP = 16'hbf30;
    localparam logic [15:0] YIELD_OP = 16'hbf10;
    localparam int unsigned OP_HI = 15;
    localparam int unsigned OP_LO = 6;
    localparam int unsigned SRC_HI = 5;
    localparam int unsigned SRC_LO = 3;
    localparam int unsigned DST_HI = 2;
    localparam int unsigned DST_LO = 0;
    localparam int unsigned BYTE_W = 8;
    localparam int unsigned HALF_W = 16;
    localparam int unsigned ROTATION = 0;
    localparam int unsigned PRIO_W = 8;
    localparam logic [REG_IDX_W-1:0] REG_IDX_RST = 3'h0;

    typedef enum logic [1:0] {
        RUN_S = 2'b00,
        WAIT_EVENT_S = 2'b01,
        WAIT_INTR_S = 2'b10
    } run_state_t;

    // one issued halfword and its condition result
    typedef struct packed {
        logic valid;
        logic cond_pass;
        logic [15:0] opcode;
    } issue_t;

    // exception wake request with its group priority (lower is higher)
    typedef struct packed {
        logic pending;
        logic [PRIO_W-1:0] group_prio;
    } wake_req_t;

    // register write port towards the register file
    typedef struct packed {
        logic en;
        logic [REG_IDX_W-1:0] idx;
        logic [DATA_W-1:0] data;
    } reg_wr_t;
endpackage

// >>> verilog/extend_and_hint_decode.sv
// decode and execute of zero-extend and wait/yield hint halfwords
// assumes one issue per cycle from fetch while not stalled; exception
// inputs come from logic on the same clock
// Contract
// - halfword bits 15..6 = 1011001011 is byte_zero_extend, low 8 bits.
// - halfword bits 15..6 = 1011001010 is halfword_zero_extend, low 16 bits.
// - source_register_index is bits 5..3, destination bits 2..0, rotation 0.
// - a failed condition leaves registers and wait state unchanged.
// - opcode 0xbf20 is wait_for_event_hint with no operand decode.
// - wait for event clears a set event register, else enters the wait.
// - any wake event, send_event_instruction included, ends the event wait.
// - opcode 0xbf30 is wait_for_interrupt_hint with no operand decode.
// - wait for interrupt suspends execution until a wake, raising nothing.
// - with priority_mask_bit set, a higher priority exception still wakes.
// - an exception not above the execution priority does not wake.
// - opcode 0xbf10 is the yield hint with no operand decode.
// - yield may swap hardware threads; this unit has none.
`timescale 1ns/10ps
module extend_and_hint_decode
    import ext_hint_pkg::*;
(
    input wire logic clk_i,
    input wire logic rst_i,
    input wire issue_t issue_i,
    input wire logic event_set_i,
    input wire logic send_event_i,
    input wire logic wake_event_i,
    input wire wake_req_t exc_i,
    input wire logic [PRIO_W-1:0] exec_prio_i,
    input wire logic priority_mask_bit_i,
    input wire reg_wr_t ext_wr_i,
    output reg_wr_t reg_wr_o,
    output logic stall_o,
    output logic low_power_o,
    output logic pc_advance_o,
    output logic event_clear_o,
    output logic flags_write_o,
    output logic exception_o,
    output logic [DATA_W-1:0] result_o
);
    function automatic logic [DATA_W-1:0] zext(
        input logic [DATA_W-1:0] v,
        input logic half
    );
        logic [DATA_W-1:0] rot;
        rot = (v >> ROTATION) | (v << (DATA_W - ROTATION));
        if (half) begin
            zext = {{(DATA_W-HALF_W){1'b0}}, rot[HALF_W-1:0]};
        end else begin
            zext = {{(DATA_W-BYTE_W){1'b0}}, rot[BYTE_W-1:0]};
        end
    endfunction

    function automatic logic op_field_is(
        input logic [15:0] op,
        input logic [9:0] code
    );
        op_field_is = op[OP_HI:OP_LO] == code;
    endfunction

    run_state_t state_r, state_nxt;
    logic pend_r, pend_nxt;
    logic fwd_r, fwd_nxt;
    logic pend_half_r, pend_half_nxt;
    logic [REG_IDX_W-1:0] pend_dst_r, pend_dst_nxt;
    reg_wr_t reg_wr_r, reg_wr_nxt;
    logic low_power_r, low_power_nxt;
    logic pc_adv_r, pc_adv_nxt;
    logic ev_clr_r, ev_clr_nxt;
    logic [DATA_W-1:0] result_r, result_nxt;
    logic [DATA_W-1:0] src_data;
    logic [DATA_W-1:0] operand;
    logic [REG_IDX_W-1:0] src_idx;
    logic is_byte, is_half, is_wfe, is_wfi, is_yield, go, exc_wake;
    reg_wr_t rf_wr;

    always_comb begin
        is_byte = op_field_is(issue_i.opcode, BYTE_ZEXT_OP);
        is_half = op_field_is(issue_i.opcode, HALF_ZEXT_OP);
        is_wfe = issue_i.opcode == WAIT_EVENT_OP;
        is_wfi = issue_i.opcode == WAIT_INTR_OP;
        is_yield = issue_i.opcode == YIELD_OP;
        src_idx = issue_i.opcode[SRC_HI:SRC_LO];
        // a result still on its way into the file comes from result_r
        operand = fwd_r ? result_r : src_data;
        // issue only accepted while running
        go = issue_i.valid && issue_i.cond_pass && (state_r == RUN_S);
        // lower number is higher priority; mask bit does not block wake
        exc_wake = exc_i.pending
            && (exc_i.group_prio < exec_prio_i);
    end

    // own writes win the port; external writes go through otherwise
    // an external write that collides with an own write is lost
    always_comb begin
        rf_wr = reg_wr_r.en ? reg_wr_r : ext_wr_i;
    end

    low_reg_file u_regs (
        .clk_i(clk_i),
        .rst_i(rst_i),
        .wr_i(rf_wr),
        .rd_idx_i(src_idx),
        .rd_data_o(src_data)
    );

    always_comb begin
        state_nxt = state_r;
        pend_nxt = 1'b0;
        fwd_nxt = 1'b0;
        pend_half_nxt = pend_half_r;
        pend_dst_nxt = pend_dst_r;
        reg_wr_nxt = '0;
        pc_adv_nxt = 1'b0;
        ev_clr_nxt = 1'b0;
        result_nxt = result_r;
        // operand read is registered; write lands two cycles after issue
        if (pend_r) begin
            result_nxt = zext(operand, pend_half_r);
            reg_wr_nxt.en = 1'b1;
            reg_wr_nxt.idx = pend_dst_r;
            reg_wr_nxt.data = result_nxt;
        end
        case (state_r)
            RUN_S: begin
                if (go) begin
                    pc_adv_nxt = 1'b1;
                    if (is_byte || is_half) begin
                        pend_nxt = 1'b1;
                        pend_half_nxt = is_half;
                        pend_dst_nxt = issue_i.opcode[DST_HI:DST_LO];
                        // the file has not yet seen the op just ahead
                        fwd_nxt = pend_r && (src_idx == pend_dst_r);
                    end else if (is_wfe) begin
                        if (event_set_i) begin
                            ev_clr_nxt = 1'b1;
                        end else begin
                            state_nxt = WAIT_EVENT_S;
                        end
                    end else if (is_wfi) begin
                        state_nxt = WAIT_INTR_S;
                    end else if (is_yield) begin
                        // single thread: nothing to swap, only the advance
                        state_nxt = RUN_S;
                    end
                end
            end
            WAIT_EVENT_S: begin
                // an exception that would end the interrupt wait ends this too
                if (wake_event_i || send_event_i || exc_wake) begin
                    state_nxt = RUN_S;
                end
            end
            WAIT_INTR_S: begin
                if (exc_wake || wake_event_i) begin
                    state_nxt = RUN_S;
                end
            end
            default: begin
                state_nxt = RUN_S;
            end
        endcase
        // stall and low power leave from one register
        low_power_nxt = state_nxt != RUN_S;
    end

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            state_r <= RUN_S;
            pend_r <= 1'b0;
            fwd_r <= 1'b0;
            pend_half_r <= 1'b0;
            pend_dst_r <= REG_IDX_RST;
            reg_wr_r <= '0;
            low_power_r <= 1'b0;
            pc_adv_r <= 1'b0;
            ev_clr_r <= 1'b0;
            result_r <= '0;
        end else begin
            state_r <= state_nxt;
            pend_r <= pend_nxt;
            fwd_r <= fwd_nxt;
            pend_half_r <= pend_half_nxt;
            pend_dst_r <= pend_dst_nxt;
            reg_wr_r <= reg_wr_nxt;
            low_power_r <= low_power_nxt;
            pc_adv_r <= pc_adv_nxt;
            ev_clr_r <= ev_clr_nxt;
            result_r <= result_nxt;
        end
    end

    // no form in this group writes flags or faults; kept as registers so
    // the outputs still leave from flip-flops
    logic flags_wr_r, flags_wr_nxt;
    logic fault_r, fault_nxt;

    always_comb begin
        flags_wr_nxt = 1'b0;
        fault_nxt = 1'b0;
    end

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            flags_wr_r <= 1'b0;
            fault_r <= 1'b0;
        end else begin
            flags_wr_r <= flags_wr_nxt;
            fault_r <= fault_nxt;
        end
    end

    assign reg_wr_o = reg_wr_r;
    assign low_power_o = low_power_r;
    assign stall_o = low_power_r;
    assign pc_advance_o = pc_adv_r;
    assign event_clear_o = ev_clr_r;
    assign flags_write_o = flags_wr_r;
    assign exception_o = fault_r;
    assign result_o = result_r;
endmodule

// >>> verilog/low_reg_file.sv
// eight-entry register file with one write port and registered read
// assumes the read index is offered one cycle before the data is needed
`timescale 1ns/10ps
module low_reg_file
    import ext_hint_pkg::*;
(
    input wire logic clk_i,
    input wire logic rst_i,
    input wire reg_wr_t wr_i,
    input wire logic [REG_IDX_W-1:0] rd_idx_i,
    output logic [DATA_W-1:0] rd_data_o
);
    logic [DATA_W-1:0] mem_r [REG_COUNT];
    logic [DATA_W-1:0] rd_data_r;
    logic [DATA_W-1:0] rd_data_nxt;

    always_comb begin
        rd_data_nxt = mem_r[rd_idx_i];
        // write-through keeps dependent ops two issues apart coherent
        if (wr_i.en && (wr_i.idx == rd_idx_i)) begin
            rd_data_nxt = wr_i.data;
        end
    end

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            for (int i = 0; i < REG_COUNT; i++) begin
                mem_r[i] <= '0;
            end
            rd_data_r <= '0;
        end else begin
            if (wr_i.en) begin
                mem_r[wr_i.idx] <= wr_i.data;
            end
            rd_data_r <= rd_data_nxt;
        end
    end

    assign rd_data_o = rd_data_r;
endmodule
